//--- logic/ufc_ctrl.sv
// fifo control register, transmit and receive fifos, trigger and time-out
// assumes the serial engines and the identification encoder sit outside
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "ufc_defines.svh"

// Operation
// [R1] control register is write-only, decoded at the identification address
// [R2] reads there return identification; writes touch only control fields
// [R3] other control fields are programmed only when fifo enable is written 1
// [R4] trigger code 0,1,2,3 selects 1, 4, 8 or 14 byte threshold
// [R5] data-ready interrupt while fill at threshold; withdrawn below it
// [R6] software always writes dma mode bit as 1 after every reset
// [R7] dma mode bit acts only with fifos enabled; 1 selects request mode
// [R8] writing 1 to bit 2 empties transmit fifo; bit self-clears
// [R9] writing 1 to bit 1 empties receive fifo; bit self-clears
// [R10] clearing fifo enable gives non-fifo mode and resets both fifos
// [R11] fifo enable set buffers transmit and receive paths through fifos
// [R12] receive fifo idle four character times while non-empty flags time-out
// [R13] reserved control bits ignored; all fields zero after reset
module ufc_ctrl #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [`UFC_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      logic [31:0]           reg_rdata,
    input  wire logic [7:0]            int_ident,
    input  wire logic                  tx_in_valid,
    input  wire logic [WIDTH-1:0]      tx_in_data,
    output      logic                  tx_in_ready,
    output      logic                  tx_out_valid,
    output      logic [WIDTH-1:0]      tx_out_data,
    input  wire logic                  tx_out_ready,
    input  wire logic                  rx_in_valid,
    input  wire logic [WIDTH-1:0]      rx_in_data,
    output      logic                  rx_in_ready,
    output      logic                  rx_out_valid,
    output      logic [WIDTH-1:0]      rx_out_data,
    input  wire logic                  rx_out_ready,
    input  wire logic                  char_tick,
    output      logic                  fifo_mode,
    output      logic                  dma_request_mode,
    output      logic [1:0]            rx_trigger_level,
    output      logic                  rx_data_ready_int,
    output      logic                  rx_timeout_int,
    output      logic                  rx_dma_req,
    output      logic                  tx_dma_req,
    output      logic                  irq
);

    ufc_pkg::ufc_ctl_state_t r;
    ufc_pkg::ufc_ctl_state_t n;

    logic                  wr_ctrl;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  tx_clear;
    logic                  rx_clear;
    logic [CW-1:0]         tx_cnt;
    logic [CW-1:0]         rx_cnt;
    logic [CW-1:0]         rx_thr;
    logic                  rx_push;
    logic                  rx_pop;
    logic                  rx_activity;
    logic                  trig_hit;
    logic                  tout_evt;
    logic                  tx_empty;
    logic [`UFC_INT_W-1:0] int_set;
    logic [`UFC_INT_W-1:0] int_clr;
    logic [31:0]           state_word;

    // threshold in bytes for each trigger code
    function automatic logic [CW-1:0] thr_of(
        input ufc_pkg::ufc_trig_t t
    );
        logic [CW-1:0] v;
        v = CW'(`UFC_TRIG_LVL0);
        case (t)
            ufc_pkg::UFC_TRIG_1: begin
                v = CW'(`UFC_TRIG_LVL0);
            end
            ufc_pkg::UFC_TRIG_4: begin
                v = CW'(`UFC_TRIG_LVL1);
            end
            ufc_pkg::UFC_TRIG_8: begin
                v = CW'(`UFC_TRIG_LVL2);
            end
            ufc_pkg::UFC_TRIG_14: begin
                v = CW'(`UFC_TRIG_LVL3);
            end
            default: begin
                v = CW'(`UFC_TRIG_LVL0);
            end
        endcase
        return v;
    endfunction

    // [R8] transmit flush
    // [R10] mode change flush
    assign tx_clear = r.tx_clr | r.mode_clr;
    // [R9] receive flush
    assign rx_clear = r.rx_clr | r.mode_clr;

    // [R11] fifo mode buffers the transmit path
    ufc_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_tx_fifo (
        .clk        (clk),
        .rst_n      (rst_n),
        .clear      (tx_clear),
        .single     (~r.fifo_en),
        .push_valid (tx_in_valid),
        .push_data  (tx_in_data),
        .push_ready (tx_in_ready),
        .pop_valid  (tx_out_valid),
        .pop_ready  (tx_out_ready),
        .pop_data   (tx_out_data),
        .count      (tx_cnt)
    );

    // [R11] fifo mode buffers the receive path
    ufc_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_rx_fifo (
        .clk        (clk),
        .rst_n      (rst_n),
        .clear      (rx_clear),
        .single     (~r.fifo_en),
        .push_valid (rx_in_valid),
        .push_data  (rx_in_data),
        .push_ready (rx_in_ready),
        .pop_valid  (rx_out_valid),
        .pop_ready  (rx_out_ready),
        .pop_data   (rx_out_data),
        .count      (rx_cnt)
    );

    assign rx_push     = rx_in_valid & rx_in_ready;
    assign rx_pop      = rx_out_ready & rx_out_valid & ~rx_clear;
    assign rx_activity = rx_push | rx_pop | rx_clear;
    assign tx_empty    = (tx_cnt == '0);

    // [R4] code to threshold
    assign rx_thr = thr_of(r.trig);

    // [R5] fill at or above threshold
    assign trig_hit = r.fifo_en & (rx_cnt >= rx_thr);

    always_comb begin
        state_word = '0;
        state_word[`UFC_BIT_FIFO_EN]  = r.fifo_en;
        state_word[`UFC_BIT_DMA_MODE] = r.dma_mode;
        state_word[`UFC_TRIG_MSB:`UFC_TRIG_LSB] = r.trig;
        state_word[`UFC_ST_RXCNT_LSB +: CW] = rx_cnt;
        state_word[`UFC_ST_TXCNT_LSB +: CW] = tx_cnt;
    end

    always_comb begin
        n          = r;
        n.tx_clr   = 1'b0;
        n.rx_clr   = 1'b0;
        n.mode_clr = 1'b0;
        n.rdata    = '0;

        // [R1] shared address decode
        wr_ctrl = reg_wr & (reg_addr == `UFC_OFF_IDENT_CTRL);
        wr_stat = reg_wr & (reg_addr == `UFC_OFF_INT_STAT);
        wr_mask = reg_wr & (reg_addr == `UFC_OFF_INT_MASK);

        if (wr_ctrl) begin
            // [R10] enable bit and flush on change
            n.fifo_en  = reg_wdata[`UFC_BIT_FIFO_EN];
            n.mode_clr = reg_wdata[`UFC_BIT_FIFO_EN] ^ r.fifo_en;
            // [R3] fields gated by enable
            // [R13] reserved bits dropped
            if (reg_wdata[`UFC_BIT_FIFO_EN]) begin
                n.trig = ufc_pkg::ufc_trig_t'(
                    reg_wdata[`UFC_TRIG_MSB:`UFC_TRIG_LSB]);
                n.dma_mode = reg_wdata[`UFC_BIT_DMA_MODE];
                // [R8] one-cycle transmit clear
                n.tx_clr   = reg_wdata[`UFC_BIT_TX_CLR];
                // [R9] one-cycle receive clear
                n.rx_clr   = reg_wdata[`UFC_BIT_RX_CLR];
            end
        end

        if (wr_mask) begin
            n.int_mask = reg_wdata[`UFC_INT_W-1:0];
        end

        // [R12] character-time idle counter
        if (!r.fifo_en || (rx_cnt == '0) || rx_activity) begin
            n.tout_cnt = '0;
        end else if (char_tick && (r.tout_cnt != `UFC_TOUT_CHARS)) begin
            n.tout_cnt = r.tout_cnt + 1'b1;
        end
        tout_evt = (n.tout_cnt == `UFC_TOUT_CHARS) &
                   (r.tout_cnt != `UFC_TOUT_CHARS);

        n.tx_empty_q = tx_empty;

        // sticky events, set wins over clear
        int_set = '0;
        int_set[`UFC_INT_RX_TRIG]  = trig_hit;
        int_set[`UFC_INT_RX_TOUT]  = tout_evt;
        int_set[`UFC_INT_TX_EMPTY] = tx_empty & ~r.tx_empty_q;

        int_clr = wr_stat ? reg_wdata[`UFC_INT_W-1:0] : '0;
        // [R5] withdraw below threshold
        int_clr[`UFC_INT_RX_TRIG] = int_clr[`UFC_INT_RX_TRIG] | ~trig_hit;
        // [R12] fifo access ends time-out
        int_clr[`UFC_INT_RX_TOUT] = int_clr[`UFC_INT_RX_TOUT] | rx_activity;

        n.int_stat = (r.int_stat & ~int_clr) | int_set;

        // [R2] reads at the control address see identification only
        if (reg_rd) begin
            case (reg_addr)
                `UFC_OFF_IDENT_CTRL: begin
                    n.rdata = {24'h00_0000, int_ident};
                end
                `UFC_OFF_INT_STAT: begin
                    n.rdata = {29'h0000_0000, r.int_stat};
                end
                `UFC_OFF_INT_MASK: begin
                    n.rdata = {29'h0000_0000, r.int_mask};
                end
                `UFC_OFF_STATE: begin
                    n.rdata = state_word;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end
    end

    // [R13] reset to zero, except tx_empty_q to one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r            <= '0;
            // fifos leave reset empty: no false empty edge
            r.tx_empty_q <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata        = r.rdata;
    assign fifo_mode        = r.fifo_en;
    assign rx_trigger_level = r.trig;

    // [R7] dma mode only with fifos on
    assign dma_request_mode = r.fifo_en & r.dma_mode;

    // [R5] enabled data-ready interrupt
    assign rx_data_ready_int = r.int_stat[`UFC_INT_RX_TRIG] &
                               r.int_mask[`UFC_INT_RX_TRIG];
    // [R12] enabled time-out interrupt
    assign rx_timeout_int    = r.int_stat[`UFC_INT_RX_TOUT] &
                               r.int_mask[`UFC_INT_RX_TOUT];

    // [R7] request lines in dma mode
    assign rx_dma_req = dma_request_mode &
                        (trig_hit | r.int_stat[`UFC_INT_RX_TOUT]);
    assign tx_dma_req = dma_request_mode & tx_empty;

    assign irq = |(r.int_stat & r.int_mask);

endmodule

//--- logic/ufc_defines.svh
// offsets, field positions, reset values and counts of the fifo control block
// assumes a byte-addressed register port with one 32-bit word per register
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

`define UFC_ADDR_W          8
`define UFC_OFF_IDENT_CTRL  8'h08
`define UFC_OFF_INT_STAT    8'h0C
`define UFC_OFF_INT_MASK    8'h10
`define UFC_OFF_STATE       8'h14

`define UFC_BIT_FIFO_EN     0
`define UFC_BIT_RX_CLR      1
`define UFC_BIT_TX_CLR      2
`define UFC_BIT_DMA_MODE    3
`define UFC_TRIG_LSB        6
`define UFC_TRIG_MSB        7
`define UFC_RST_CTRL        8'h00

`define UFC_INT_W           3
`define UFC_INT_RX_TRIG     0
`define UFC_INT_RX_TOUT     1
`define UFC_INT_TX_EMPTY    2
`define UFC_RST_INT         3'h0

`define UFC_ST_RXCNT_LSB    8
`define UFC_ST_TXCNT_LSB    16

`define UFC_TRIG_LVL0       8'h01
`define UFC_TRIG_LVL1       8'h04
`define UFC_TRIG_LVL2       8'h08
`define UFC_TRIG_LVL3       8'h0E

`define UFC_TOUT_CHARS      3'h4

`endif

//--- logic/ufc_fifo.sv
// one character fifo with occupancy count, clear and single-entry mode
// assumes clear and single come from flops of the same clock domain
`timescale 1ns/1ns

module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1),
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             single,
    input  wire logic             push_valid,
    input  wire logic [WIDTH-1:0] push_data,
    output      logic             push_ready,
    output      logic             pop_valid,
    input  wire logic             pop_ready,
    output      logic [WIDTH-1:0] pop_data,
    output      logic [CW-1:0]    count
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } ufc_fifo_state_t;

    ufc_fifo_state_t r;
    ufc_fifo_state_t n;
    logic            full;
    logic            do_push;
    logic            do_pop;

    always_comb begin
        // non-fifo mode holds just one character
        full       = single ? (r.cnt != '0) : (r.cnt == CW'(DEPTH));
        push_ready = ~full & ~clear;
        do_push    = push_valid & push_ready;
        do_pop     = pop_ready & (r.cnt != '0) & ~clear;
        n          = r;
        if (clear) begin
            n.wp  = '0;
            n.rp  = '0;
            n.cnt = '0;
        end else begin
            if (do_push) begin
                n.mem[r.wp] = push_data;
                n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
            end
            if (do_pop) begin
                n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
            end
            case ({do_push, do_pop})
                2'b10: begin
                    n.cnt = r.cnt + 1'b1;
                end
                2'b01: begin
                    n.cnt = r.cnt - 1'b1;
                end
                default: begin
                    n.cnt = r.cnt;
                end
            endcase
        end
    end

    assign pop_valid = (r.cnt != '0);
    assign pop_data  = r.mem[r.rp];
    assign count     = r.cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

//--- logic/ufc_pkg.sv
// types shared by the fifo control block
// assumes ufc_defines.svh is on the include path
`include "ufc_defines.svh"

package ufc_pkg;

    typedef enum logic [1:0] {
        UFC_TRIG_1  = 2'b00,
        UFC_TRIG_4  = 2'b01,
        UFC_TRIG_8  = 2'b10,
        UFC_TRIG_14 = 2'b11
    } ufc_trig_t;

    typedef struct packed {
        logic                  fifo_en;
        ufc_trig_t             trig;
        logic                  dma_mode;
        logic                  tx_clr;
        logic                  rx_clr;
        logic                  mode_clr;
        logic [`UFC_INT_W-1:0] int_stat;
        logic [`UFC_INT_W-1:0] int_mask;
        logic [2:0]            tout_cnt;
        logic                  tx_empty_q;
        logic [31:0]           rdata;
    } ufc_ctl_state_t;

endpackage

//--- tb/ufc_ctrl_properties.sv
// checker of the fifo control block, bound to its top module
// assumes ufc_defines.svh is on the include path
`timescale 1ns/1ns
`include "ufc_defines.svh"

module ufc_ctrl_properties #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = 5
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic [`UFC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire logic [7:0]             int_ident,
    input wire logic                   rx_in_ready,
    input wire logic                   rx_out_valid,
    input wire logic                   tx_out_valid,
    input wire logic                   fifo_mode,
    input wire logic                   dma_request_mode,
    input wire logic [1:0]             rx_trigger_level,
    input wire logic                   rx_data_ready_int,
    input wire logic                   rx_timeout_int,
    input wire logic                   rx_dma_req,
    input wire logic                   tx_dma_req,
    input wire logic                   irq
);
    wire w08 = reg_wr && (reg_addr == `UFC_OFF_IDENT_CTRL);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd_id;
        reg_rd && (reg_addr == `UFC_OFF_IDENT_CTRL);
    endsequence
    sequence s_rx_clr;
        w08 && reg_wdata[1:0] == 2'h3;
    endsequence
    sequence s_tx_clr;
        w08 && reg_wdata[2] && reg_wdata[0];
    endsequence

    AST_RD_IDENT: assert property (s_rd_id |=>
        reg_rdata == {24'h0, $past(int_ident)}) else $error("ident read");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    AST_WR_EN: assert property (w08 && reg_wdata[0] |=> fifo_mode &&
        rx_trigger_level == $past(reg_wdata[7:6])) else $error("trigger");
    AST_WR_OFF: assert property (w08 && !reg_wdata[0] |=> !fifo_mode &&
        $stable(rx_trigger_level)) else $error("field taken without enable");
    AST_DMA: assert property (dma_request_mode |-> fifo_mode)
        else $error("dma mode outside fifo mode");
    AST_DMA_SET: assert property (w08 && reg_wdata[0] |=>
        dma_request_mode == $past(reg_wdata[3])) else $error("dma mode");
    AST_ONE: assert property (!fifo_mode && rx_out_valid |->
        !rx_in_ready) else $error("second entry in non-fifo mode");
    AST_TX_DMA: assert property (tx_dma_req |-> dma_request_mode &&
        !tx_out_valid) else $error("transmit dma request");
    AST_RX_DMA: assert property (rx_dma_req |-> dma_request_mode)
        else $error("receive dma request");
    AST_IRQ: assert property (rx_data_ready_int || rx_timeout_int |->
        irq) else $error("interrupt line low");
    AST_RX_CLR: assert property (s_rx_clr |-> ##2 !rx_out_valid)
        else $error("receive fifo not emptied");
    AST_TX_CLR: assert property (s_tx_clr |-> ##2 !tx_out_valid)
        else $error("transmit fifo not emptied");
endmodule

bind ufc_ctrl ufc_ctrl_properties #(.WIDTH(WIDTH), .DEPTH(DEPTH), .CW(CW))
    ufc_ctrl_properties_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .int_ident, .rx_in_ready, .rx_out_valid,
    .tx_out_valid, .fifo_mode, .dma_request_mode, .rx_trigger_level,
    .rx_data_ready_int, .rx_timeout_int, .rx_dma_req, .tx_dma_req, .irq);

//--- tb/ufc_ctrl_tb.sv
// self-checking bench of the fifo control block
// assumes the checker is bound to the design by its own file
`timescale 1ns/1ns
`include "ufc_defines.svh"

module ufc_ctrl_tb;
    logic        clk, rst_n, reg_wr, reg_rd, char_tick;
    logic        tx_in_valid, tx_out_ready, rx_in_valid, rx_out_ready;
    logic        tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
    logic        fifo_mode, dma_request_mode, rx_data_ready_int;
    logic        rx_timeout_int, rx_dma_req, tx_dma_req, irq;
    logic [1:0]  rx_trigger_level;
    logic [7:0]  reg_addr, int_ident, tx_in_data, rx_in_data;
    logic [7:0]  tx_out_data, rx_out_data;
    logic [31:0] reg_wdata, reg_rdata, seed, d;
    logic [7:0]  rxq[$], txq[$];
    int          errors, cmp_count, t;
    int          cyc_cnt = 0;

    ufc_ctrl ufc_ctrl_inst (
        .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .int_ident, .tx_in_valid, .tx_in_data, .tx_in_ready, .tx_out_valid,
        .tx_out_data, .tx_out_ready, .rx_in_valid, .rx_in_data, .rx_in_ready,
        .rx_out_valid, .rx_out_data, .rx_out_ready, .char_tick, .fifo_mode,
        .dma_request_mode, .rx_trigger_level, .rx_data_ready_int,
        .rx_timeout_int, .rx_dma_req, .tx_dma_req, .irq
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int thr(input logic [1:0] c);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 4 : (c == 2'h2) ? 8 : 14;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic rxp(input int n);
        @(posedge clk);
        rx_in_valid <= 1'b1;
        repeat (n) begin
            seed = lfsr(seed);
            rx_in_data <= seed[7:0];
            rxq.push_back(seed[7:0]);
            do @(posedge clk); while (rx_in_ready !== 1'b1);
        end
        rx_in_valid <= 1'b0;
    endtask

    task automatic txp(input int n);
        @(posedge clk);
        tx_in_valid <= 1'b1;
        repeat (n) begin
            seed = lfsr(seed);
            tx_in_data <= seed[7:0];
            txq.push_back(seed[7:0]);
            do @(posedge clk); while (tx_in_ready !== 1'b1);
        end
        tx_in_valid <= 1'b0;
    endtask

    // pops n characters and compares them in arrival order
    task automatic rxpop(input int n);
        @(posedge clk);
        rx_out_ready <= 1'b1;
        repeat (n) begin
            @(posedge clk);
            chk({24'h0, rx_out_data}, {24'h0, rxq.pop_front()});
        end
        rx_out_ready <= 1'b0;
    endtask

    task automatic tick;
        @(posedge clk);
        char_tick <= 1'b1;
        @(posedge clk);
        char_tick <= 1'b0;
    endtask

    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            errors++;
            complete_run;
        end
    end

    initial begin
        {reg_wr, reg_rd, char_tick, tx_in_valid, tx_out_ready} = 5'h0;
        {rx_in_valid, rx_out_ready, rst_n} = 3'h0;
        {reg_addr, tx_in_data, rx_in_data} = 24'h0;
        reg_wdata = 32'h0;
        errors = 0;
        cmp_count = 0;
        seed = 32'h3B539A79;
        int_ident = seed[7:0];
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0);
        rd(`UFC_OFF_INT_STAT);
        chk(d, 32'h0);
        rd(`UFC_OFF_IDENT_CTRL);
        chk(d, {24'h0, int_ident});
        rd(8'h20);
        chk(d, 32'h0);
        rxp(1);
        @(negedge clk);
        chk(rx_in_ready, 1'b0);
        rxpop(1);
        wr(`UFC_OFF_IDENT_CTRL, 32'hC8);
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0);
        wr(`UFC_OFF_INT_MASK, 32'h7);
        for (int c = 0; c < 4; c++) begin
            wr(`UFC_OFF_IDENT_CTRL, {24'hFFFFFF, c[1:0], 6'h39});
            rd(`UFC_OFF_STATE);
            chk(d, {24'h0, c[1:0], 6'h09});
            chk(dma_request_mode, 1'b1);
            chk(tx_dma_req, 1'b1);
            t = thr(c[1:0]);
            if (t > 1) begin
                rxp(t - 1);
                settle;
                chk(rx_data_ready_int, 1'b0);
                chk(rx_dma_req, 1'b0);
            end
            rxp(1);
            settle;
            chk(rx_data_ready_int, 1'b1);
            chk(rx_dma_req, 1'b1);
            rxpop(1);
            settle;
            chk(rx_data_ready_int, 1'b0);
            if (t > 1)
                rxpop(t - 1);
            wr(`UFC_OFF_INT_STAT, 32'h7);
        end
        wr(`UFC_OFF_IDENT_CTRL, 32'h09);
        rxp(3);
        txp(2);
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0002_0309);
        chk(tx_dma_req, 1'b0);
        @(posedge clk);
        tx_out_ready <= 1'b1;
        @(posedge clk);
        chk({24'h0, tx_out_data}, {24'h0, txq.pop_front()});
        tx_out_ready <= 1'b0;
        wr(`UFC_OFF_IDENT_CTRL, 32'h0D);
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0000_0309);
        chk(tx_dma_req, 1'b1);
        wr(`UFC_OFF_IDENT_CTRL, 32'h0B);
        rxq.delete();
        rxp(2);
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0000_0209);
        wr(`UFC_OFF_INT_STAT, 32'h7);
        repeat (3) tick;
        settle;
        chk(rx_timeout_int, 1'b0);
        tick;
        settle;
        chk(rx_timeout_int, 1'b1);
        chk(irq, 1'b1);
        wr(`UFC_OFF_INT_MASK, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
        rd(`UFC_OFF_INT_STAT);
        chk(d & 32'h2, 32'h2);
        rxpop(1);
        rd(`UFC_OFF_INT_STAT);
        chk(d & 32'h2, 32'h0);
        wr(`UFC_OFF_IDENT_CTRL, 32'h08);
        @(negedge clk);
        chk(dma_request_mode, 1'b0);
        wr(`UFC_OFF_IDENT_CTRL, 32'hC8);
        rd(`UFC_OFF_STATE);
        chk(d, 32'h0000_0008);
        chk(fifo_mode, 1'b0);
        complete_run;
    end
endmodule
